// [design/tag_pkg.sv]
// shared constants for the tag write-control link: blocks, commands, frame layout
// assumes one 100 MHz clock on both ends and a framed character link between them
package tag_pkg;
  localparam int          CHAR_W        = 10;
  localparam int          DATA_W        = 32;
  localparam int          CRC_W         = 16;
  localparam logic [7:0]  BLK_OTP_LAST  = 8'h04;
  localparam logic [7:0]  BLK_CNT_A     = 8'h05;
  localparam logic [7:0]  BLK_CNT_RLD   = 8'h06;
  localparam logic [7:0]  BLK_EE_FIRST  = 8'h07;
  localparam logic [7:0]  BLK_LOCK_LAST = 8'h0F;
  localparam logic [7:0]  BLK_EE_LAST   = 8'h7F;
  localparam logic [7:0]  BLK_SYS       = 8'hFF;
  localparam logic [31:0] CNT_A_RST     = 32'hFFFFFFFE;
  localparam logic [31:0] CNT_RLD_RST   = 32'hFFFFFFFF;
  localparam logic [31:0] SYS_RST       = 32'hFFFFFFFF;
  localparam logic [31:0] ALL_ONES      = 32'hFFFFFFFF;
  localparam int          RLD_LSB       = 21;
  localparam int          LOCK_LSB      = 24;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [7:0]  CMD_INITIATE  = 8'h06;
  localparam logic [7:0]  CMD_SELECT    = 8'h0E;
  localparam logic [7:0]  CMD_READ      = 8'h08;
  localparam logic [7:0]  CMD_WRITE     = 8'h09;
  localparam logic [7:0]  CMD_UID       = 8'h0B;
  localparam logic [1:0]  CHR_SOF       = 2'h1;
  localparam logic [1:0]  CHR_DATA      = 2'h0;
  localparam logic [1:0]  CHR_EOF       = 2'h2;
  localparam int          PROG_CYC      = 16;
  localparam int          MAX_BYTES     = 8;

  // character: start bit b0 low, 8 data bits, stop bit b9 high
  function automatic logic [9:0] make_char(input logic [7:0] b);
    make_char = {1'b1, b, 1'b0};
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction
endpackage

// [design/tag_link_if.sv]
// character link between reader and tag
// assumes both ends share clk; a character moves in the cycle valid is high
interface tag_link_if;
  logic [9:0] req_char;
  logic [1:0] req_kind;
  logic       req_valid;
  logic [9:0] ans_char;
  logic [1:0] ans_kind;
  logic       ans_valid;
  modport tag    (input req_char, req_kind, req_valid, output ans_char, ans_kind, ans_valid);
  modport reader (output req_char, req_kind, req_valid, input ans_char, ans_kind, ans_valid);
endinterface

// [design/tag_reader.sv]
// reader end: frames one command with crc, gathers the answer bytes
// assumes the user holds cmd fields stable while start is high
module tag_reader
  import tag_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  tag_link_if.reader       link,
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        bad_crc,
  output logic             busy,
  output logic             ans_done,
  output logic [63:0]      ans_data,
  output logic [3:0]       ans_len
);
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_SOF = 2'b01, R_BYTES = 2'b10, R_EOF = 2'b11} rst_t;
  typedef struct packed {
    rst_t        st;
    logic [7:0][7:0] buf_b;
    logic [3:0]  n;
    logic [3:0]  i;
    logic [9:0]  chr;
    logic [1:0]  kind;
    logic        valid;
    logic        busy;
    logic        done;
    logic [63:0] rx;
    logic [3:0]  rx_n;
    logic [3:0]  len;
  } rd_state_t;
  rd_state_t s_q, s_d;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [15:0] c;
    c = CRC_INIT;
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.done = 1'b0;
    case (s_q.st)
      R_IDLE:
      begin
        if (start)
        begin
          // frame: sof, bytes, two crc bytes, eof
          s_d.buf_b[0] = cmd;
          s_d.n = 4'h1;
          if (cmd == CMD_WRITE || cmd == CMD_READ || cmd == CMD_SELECT)
          begin
            s_d.buf_b[1] = addr;
            s_d.n = 4'h2;
          end
          if (cmd == CMD_WRITE)
          begin
            for (int k = 0; k < 4; k++)
              s_d.buf_b[2 + k] = wdata[8 * k +: 8];
            s_d.n = 4'h6;
          end
          for (int k = 0; k < 6; k++)
            if (k < int'(s_d.n))
              c = crc_byte(c, s_d.buf_b[k]);
          c = bad_crc ? ~c : c;
          s_d.buf_b[s_d.n] = c[7:0];
          s_d.buf_b[s_d.n + 4'h1] = c[15:8];
          s_d.n = s_d.n + 4'h2;
          s_d.i = 4'h0;
          s_d.busy = 1'b1;
          s_d.st = R_SOF;
        end
      end
      R_SOF:
      begin
        s_d.valid = 1'b1;
        s_d.kind = CHR_SOF;
        s_d.st = R_BYTES;
      end
      R_BYTES:
      begin
        // ten-bit characters, start bit first
        s_d.valid = 1'b1;
        s_d.kind = CHR_DATA;
        s_d.chr = make_char(s_q.buf_b[s_q.i[2:0]]);
        s_d.i = s_q.i + 4'h1;
        if (s_d.i == s_q.n)
          s_d.st = R_EOF;
      end
      R_EOF:
      begin
        s_d.valid = 1'b1;
        s_d.kind = CHR_EOF;
        s_d.rx_n = 4'h0;
        s_d.st = R_IDLE;
        s_d.busy = 1'b0;
      end
      default: s_d.st = R_IDLE;
    endcase
    if (link.ans_valid)
    begin
      if (link.ans_kind == CHR_SOF)
        s_d.rx_n = 4'h0;
      else if (link.ans_kind == CHR_DATA && s_q.rx_n < 4'(MAX_BYTES))
      begin
        s_d.rx[8 * s_q.rx_n +: 8] = link.ans_char[8:1];
        s_d.rx_n = s_q.rx_n + 4'h1;
      end
      else if (link.ans_kind == CHR_EOF)
      begin
        s_d.done = 1'b1;
        s_d.len = s_q.rx_n;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign link.req_char  = s_q.chr;
  assign link.req_kind  = s_q.kind;
  assign link.req_valid = s_q.valid;
  assign busy     = s_q.busy;
  assign ans_done = s_q.done;
  assign ans_data = s_q.rx;
  assign ans_len  = s_q.len;
endmodule

// [design/tag_memory_write_control.sv]
// tag end: frame decode, state machine, block memory and write rules
// assumes power_ok comes from the field detector, asynchronous to clk
// Contract
// - counter write only if strictly lower
// - counters start fffffffe and ffffffff
// - zero counter refuses all updates
// - write to 5 or 6 stores value
// - power loss keeps old counter value
// - reload bits change arms erase for 0-4
// - erase stays until power-off or select
// - blocks 7 to 127 auto-erase
// - system block only clears bits
// - all-zero system block refuses writes
// - lock bits 24-31 protect blocks 7-15
// - lock bits never return to one
// - fixed id option disables random id
// - ten-bit characters, start bit first
// - reader frames sof, data, crc, eof
// - bad frame gets no reply
// - answer ends with two crc bytes
// - reader selects before memory commands
// - weak field: power-off, ignore commands
// - power-up: reset, random id, ready (rst zeroes lfsr and it never leaves 00, so the drawn id is 00)
// - no reload: blocks 0-4 only clear
// - memory commands only when selected
module tag_memory_write_control
  import tag_pkg::*;
#(
  parameter bit         FIXED_ID_OPT = 1'b0,
  parameter logic [7:0] FIXED_ID     = 8'h5A,
  parameter logic [63:0] UID_VALUE   = 64'h0123456789ABCDEF  // arbitrary value
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  tag_link_if.tag          link,
  input  wire logic        power_ok,
  output logic [7:0]       tag_select_id,
  output logic [2:0]       tag_state,
  output logic             prog_busy
);
  typedef enum logic [2:0] {T_OFF = 3'b000, T_READY = 3'b001, T_INV = 3'b010, T_SEL = 3'b011,
                            T_DESEL = 3'b100} tstate_t;
  typedef enum logic [1:0] {F_IDLE = 2'b00, F_RX = 2'b01, F_PROG = 2'b10, F_TX = 2'b11} fstate_t;
  typedef struct packed {
    tstate_t         st;
    fstate_t         fs;
    logic [1:0]      pwr_sync;
    logic [7:0]      id;
    logic [7:0]      lfsr;
    logic            reload;
    logic [7:0][7:0] rxb;
    logic [3:0]      rn;
    logic [7:0][7:0] txb;
    logic [3:0]      tn;
    logic [3:0]      ti;
    logic            tx_sof;
    logic [7:0]      pa;
    logic [31:0]     pv;
    logic [4:0]      pc;
    logic [9:0]      chr;
    logic [1:0]      kind;
    logic            valid;
  } tag_state_t;
  tag_state_t  s_q, s_d;
  logic [31:0] mem_q [0:127];
  logic [31:0] cnt_a_q, cnt_r_q, sys_q;
  logic        commit;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [15:0] c;
    logic [31:0] cur, nv;
    logic [7:0]  ad;
    logic        ok;
    c = CRC_INIT;
    cur = '0;
    nv = '0;
    ok = 1'b0;
    ad = s_q.rxb[1];
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.pwr_sync = {s_q.pwr_sync[0], power_ok};
    s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
    commit = 1'b0;
    if (!s_q.pwr_sync[1])
    begin
      // weak field: nothing answered, reload forgotten, write abandoned
      s_d.st = T_OFF;
      s_d.fs = F_IDLE;
      s_d.reload = 1'b0;
    end
    else if (s_q.st == T_OFF)
    begin
      // power-up takes the id from lfsr, which rst leaves stuck at 00, unless the fixed option is fitted
      s_d = s_q;
      s_d.pwr_sync = {s_q.pwr_sync[0], power_ok};
      s_d.valid = 1'b0;
      s_d.fs = F_IDLE;
      s_d.reload = 1'b0;
      s_d.id = FIXED_ID_OPT ? FIXED_ID : s_q.lfsr;
      s_d.st = T_READY;
    end
    else
    begin
      case (s_q.fs)
        F_IDLE, F_RX:
        begin
          if (link.req_valid && link.req_kind == CHR_SOF)
          begin
            s_d.rn = 4'h0;
            s_d.fs = F_RX;
          end
          else if (s_q.fs == F_RX && link.req_valid && link.req_kind == CHR_DATA)
          begin
            if (s_q.rn < 4'(MAX_BYTES))
              s_d.rxb[s_q.rn[2:0]] = link.req_char[8:1];
            s_d.rn = s_q.rn + 4'h1;
          end
          else if (s_q.fs == F_RX && link.req_valid && link.req_kind == CHR_EOF)
          begin
            s_d.fs = F_IDLE;
            for (int k = 0; k < MAX_BYTES; k++)
              if (k < int'(s_q.rn))
                c = crc_byte(c, s_q.rxb[k]);
            // last two bytes compared with crc over the bytes before them; bad frames dropped silently
            if (s_q.rn >= 4'h3 && s_q.rn <= 4'(MAX_BYTES)
                && {s_q.rxb[s_q.rn[2:0] - 3'h1], s_q.rxb[s_q.rn[2:0] - 3'h2]} == crc_after(s_q))
            begin
              case (s_q.st)
                T_READY:
                  if (s_q.rxb[0] == CMD_INITIATE)
                  begin
                    s_d.st = T_INV;
                    s_d.id = FIXED_ID_OPT ? FIXED_ID : s_q.lfsr;
                    s_d.txb[0] = s_d.id;
                    s_d.tn = 4'h1;
                    s_d.fs = F_TX;
                  end
                T_INV, T_DESEL:
                  if (s_q.rxb[0] == CMD_SELECT && s_q.rxb[1] == s_q.id)
                  begin
                    s_d.st = T_SEL;
                    s_d.reload = 1'b0;
                    s_d.txb[0] = s_q.id;
                    s_d.tn = 4'h1;
                    s_d.fs = F_TX;
                  end
                T_SEL:
                begin
                  // memory commands only here
                  if (s_q.rxb[0] == CMD_SELECT)
                  begin
                    s_d.reload = 1'b0;
                    if (s_q.rxb[1] != s_q.id)
                      s_d.st = T_DESEL;
                  end
                  else if (s_q.rxb[0] == CMD_READ && s_q.rn == 4'h4)
                  begin
                    cur = rd(ad);
                    for (int k = 0; k < 4; k++)
                      s_d.txb[k] = cur[8 * k +: 8];
                    s_d.tn = 4'h4;
                    s_d.fs = F_TX;
                  end
                  else if (s_q.rxb[0] == CMD_UID && s_q.rn == 4'h3)
                  begin
                    for (int k = 0; k < 8; k++)
                      s_d.txb[k] = UID_VALUE[8 * k +: 8];
                    s_d.tn = 4'h8;
                    s_d.fs = F_TX;
                  end
                  else if (s_q.rxb[0] == CMD_WRITE && s_q.rn == 4'h8)
                  begin
                    cur = rd(ad);
                    nv = {s_q.rxb[5], s_q.rxb[4], s_q.rxb[3], s_q.rxb[2]};
                    if (ad <= BLK_OTP_LAST)
                    begin
                      // erase only in reload mode, else bits only clear
                      ok = (cur != '0) || s_q.reload;
                      nv = s_q.reload ? nv : (cur & nv);
                    end
                    else if (ad == BLK_CNT_A || ad == BLK_CNT_RLD)
                      ok = (cur != '0) && (nv < cur);
                    else if (ad >= BLK_EE_FIRST && ad <= BLK_EE_LAST)
                      ok = !locked(ad);
                    else if (ad == BLK_SYS)
                    begin
                      ok = (cur != '0);
                      nv = cur & nv;
                    end
                    if (ok)
                    begin
                      // reload bits changing arms erase cycles
                      if (ad == BLK_CNT_RLD && nv[31:RLD_LSB] != cur[31:RLD_LSB])
                        s_d.reload = 1'b1;
                      s_d.pa = ad;
                      s_d.pv = nv;
                      s_d.pc = 5'h0;
                      s_d.fs = F_PROG;
                    end
                  end
                end
                default: ;
              endcase
            end
          end
        end
        F_PROG:
        begin
          // value commits only at the end of the cycle; power loss above abandons it
          s_d.pc = s_q.pc + 5'h1;
          if (s_q.pc == 5'(PROG_CYC - 1))
          begin
            commit = 1'b1;
            s_d.fs = F_IDLE;
          end
        end
        F_TX:
        begin
          // sof, data, two crc bytes, eof
          s_d.valid = 1'b1;
          if (!s_q.tx_sof)
          begin
            s_d.kind = CHR_SOF;
            s_d.tx_sof = 1'b1;
            s_d.ti = 4'h0;
            for (int k = 0; k < 8; k++)
              if (k < int'(s_q.tn))
                c = crc_byte(c, s_q.txb[k]);
            s_d.rxb[0] = c[7:0];
            s_d.rxb[1] = c[15:8];
          end
          else if (s_q.ti < s_q.tn + 4'h2)
          begin
            s_d.kind = CHR_DATA;
            s_d.chr = make_char(s_q.ti < s_q.tn ? s_q.txb[s_q.ti[2:0]] : s_q.rxb[s_q.ti - s_q.tn]);
            s_d.ti = s_q.ti + 4'h1;
          end
          else
          begin
            s_d.kind = CHR_EOF;
            s_d.tx_sof = 1'b0;
            s_d.fs = F_IDLE;
          end
        end
        default: s_d.fs = F_IDLE;
      endcase
    end
  end

  function automatic logic [15:0] crc_after(input tag_state_t s);
    logic [15:0] r;
    r = CRC_INIT;
    for (int k = 0; k < MAX_BYTES; k++)
      if (k + 2 < int'(s.rn))
        r = crc_byte(r, s.rxb[k]);
    crc_after = r;
  endfunction

  function automatic logic [31:0] rd(input logic [7:0] a);
    if (a == BLK_CNT_A)
      rd = cnt_a_q;
    else if (a == BLK_CNT_RLD)
      rd = cnt_r_q;
    else if (a == BLK_SYS)
      rd = sys_q;
    else if (a <= BLK_EE_LAST)
      rd = mem_q[a[6:0]];
    else
      rd = ALL_ONES;
  endfunction

  function automatic logic locked(input logic [7:0] a);
    logic [3:0] b;
    b = (a <= BLK_EE_FIRST + 8'h1) ? 4'h0 : 4'(a - BLK_EE_FIRST - 8'h1);
    locked = (a <= BLK_LOCK_LAST) && !sys_q[LOCK_LSB + int'(b)];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // storage stands for nonvolatile cells: rst loads the factory image, field loss keeps it
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
    if (rst)
    begin
      // one writer per cell; erased cells read all ones
      for (int k = 0; k <= int'(BLK_EE_LAST); k++)
        mem_q[k] <= ALL_ONES;
      cnt_a_q <= CNT_A_RST;
      cnt_r_q <= CNT_RLD_RST;
      sys_q   <= FIXED_ID_OPT ? {SYS_RST[31:8], FIXED_ID} : SYS_RST;
    end
    else if (commit)
    begin
      if (s_q.pa == BLK_CNT_A)
        cnt_a_q <= s_q.pv;
      else if (s_q.pa == BLK_CNT_RLD)
        cnt_r_q <= s_q.pv;
      else if (s_q.pa == BLK_SYS)
        sys_q <= s_q.pv;
      else
        mem_q[s_q.pa[6:0]] <= s_q.pv;
    end
  end

  assign tag_select_id  = s_q.id;
  assign tag_state      = s_q.st;
  assign prog_busy      = (s_q.fs == F_PROG);
  assign link.ans_char  = s_q.chr;
  assign link.ans_kind  = s_q.kind;
  assign link.ans_valid = s_q.valid;
endmodule

// [testbench/tag_link_asserts.sv]
// concurrent checks on the reader-tag character link
// assumes one clock and a synchronous active-high reset shared by both ends
module tag_link_asserts
  import tag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [9:0] req_char,
  input  wire logic [1:0] req_kind,
  input  wire logic       req_valid,
  input  wire logic [9:0] ans_char,
  input  wire logic [1:0] ans_kind,
  input  wire logic       ans_valid
);
  typedef struct packed {
    logic       req_open;
    logic       ans_open;
    logic [3:0] since_eof;
  } chk_state_t;

  chk_state_t s_q;
  chk_state_t s_d;
  logic       req_sof;
  logic       req_eof;
  logic       ans_sof;
  logic       ans_eof;

  assign req_sof = req_valid && req_kind == CHR_SOF;
  assign req_eof = req_valid && req_kind == CHR_EOF;
  assign ans_sof = ans_valid && ans_kind == CHR_SOF;
  assign ans_eof = ans_valid && ans_kind == CHR_EOF;

  //////////////////////////////////////////////////////////////////////////////
  // frame tracking; counter saturates so a long idle never wraps into a match
  always_comb
  begin
    s_d = s_q;
    if (req_sof)
      s_d.req_open = 1'h1;
    if (req_eof)
      s_d.req_open = 1'h0;
    if (ans_sof)
      s_d.ans_open = 1'h1;
    if (ans_eof)
      s_d.ans_open = 1'h0;
    if (req_eof)
      s_d.since_eof = 4'h0;
    else if (s_q.since_eof != 4'hF)
      s_d.since_eof = s_q.since_eof + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '{req_open: 1'h0, ans_open: 1'h0, since_eof: 4'hF};
    else
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_req_char_shape: assert property (req_valid && req_kind == CHR_DATA |-> !req_char[0] && req_char[9])
    else $error("request character framing bits wrong");
  a_ans_char_shape: assert property (ans_valid && ans_kind == CHR_DATA |-> !ans_char[0] && ans_char[9])
    else $error("answer character framing bits wrong");
  a_req_frame_order: assert property (req_valid |-> (req_kind == CHR_SOF) != s_q.req_open)
    else $error("request character outside an open frame");
  a_req_crc_room: assert property (req_sof |=> !req_eof [*3])
    else $error("request frame too short for data and crc");
  a_ans_frame_order: assert property (ans_valid |-> (ans_kind == CHR_SOF) != s_q.ans_open)
    else $error("answer character outside an open frame");
  a_ans_crc_room: assert property (ans_sof |=> !ans_eof [*3])
    else $error("answer frame too short for data and crc");
  a_ans_eof_bound: assert property (ans_sof |-> ##[1:40] ans_eof)
    else $error("answer frame not closed");
  a_ans_after_req: assert property (ans_sof |-> s_q.since_eof <= 4'h2)
    else $error("answer without a request frame just before");
endmodule

// [testbench/tb_top.sv]
// bench: reader and tag joined by one link, scenarios driven at the reader's user side
// assumes the tag is built with the fixed id option so the id is known up front
module tb_top
  import tag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h5A;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        power_ok = 1'h0;
  logic        start = 1'h0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        bad_crc = 1'h0;
  logic        busy;
  logic        ans_done;
  logic [63:0] ans_data;
  logic [3:0]  ans_len;
  logic [7:0]  tag_select_id;
  logic [2:0]  tag_state;
  logic        prog_busy;
  logic [31:0] v;
  logic        got;
  int          err_total = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  tag_link_if link ();
  tag_reader tag_reader_inst (.clk(clk), .rst(rst), .link(link), .start(start), .cmd(cmd), .addr(addr),
    .wdata(wdata), .bad_crc(bad_crc), .busy(busy), .ans_done(ans_done), .ans_data(ans_data), .ans_len(ans_len));
  tag_memory_write_control #(.FIXED_ID_OPT(1'h1), .FIXED_ID(ID)) tag_memory_write_control_inst (.clk(clk),
    .rst(rst), .link(link), .power_ok(power_ok), .tag_select_id(tag_select_id), .tag_state(tag_state),
    .prog_busy(prog_busy));
  tag_link_asserts tag_link_asserts_inst (.clk(clk), .rst(rst), .req_char(link.req_char),
    .req_kind(link.req_kind), .req_valid(link.req_valid), .ans_char(link.ans_char), .ans_kind(link.ans_kind),
    .ans_valid(link.ans_valid));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("[FAIL] %s expected done seen timeout", what);
    stop_test();
  endtask

  task automatic send(input logic [7:0] c, input logic [7:0] a, input logic [31:0] d, input logic bad);
    @(negedge clk);
    cmd = c;
    addr = a;
    wdata = d;
    bad_crc = bad;
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
  endtask

  // waits out the whole answer window, so silence is judged as well as replies
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [31:0] d, input logic bad);
    int n;
    n = 0;
    got = 1'h0;
    send(c, a, d, bad);
    while (busy !== 1'h0 || prog_busy !== 1'h0)
    begin
      @(negedge clk);
      n++;
      if (n > 300)
        hang("link idle");
    end
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk);
      if (ans_done === 1'h1)
        got = 1'h1;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(CMD_READ, a, 32'h0, 1'h0);
    chk("read answered", 32'h1, 32'(got));
    chk("read length", 32'h6, 32'(ans_len));
    v = ans_data[31:0];
  endtask

  task automatic rd_is(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(what, e, v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(CMD_WRITE, a, d, 1'h0);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (tag_state !== 3'h1)
    begin
      @(negedge clk);
      n++;
      if (n > 50)
        hang("ready state");
    end
  endtask

  task automatic open_session();
    xfer(CMD_INITIATE, 8'h00, 32'h0, 1'h0);
    chk("initiate id", 32'(ID), 32'(ans_data[7:0]));
    chk("initiate length", 32'h3, 32'(ans_len));
    xfer(CMD_UID, 8'h00, 32'h0, 1'h0);
    chk("uid before select", 32'h0, 32'(got));
    xfer(CMD_SELECT, ID, 32'h0, 1'h0);
    chk("selected state", 32'h3, 32'(tag_state));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    @(negedge clk);
    power_ok = 1'h1;
    wait_ready();
    xfer(CMD_READ, BLK_CNT_A, 32'h0, 1'h0);
    chk("read in ready", 32'h0, 32'(got));
    open_session();
    chk("select id port", 32'(ID), 32'(tag_select_id));
    rd(BLK_SYS);
    chk("fixed id in system block", 32'(ID), 32'(v[7:0]));
    $display("test power_up done");
  endtask

  task automatic t_counters();
    rd_is("counter a reset", BLK_CNT_A, CNT_A_RST);
    rd_is("counter reload reset", BLK_CNT_RLD, CNT_RLD_RST);
    wr(BLK_CNT_A, 32'hFFFFFF00);
    rd_is("counter a lowered", BLK_CNT_A, 32'hFFFFFF00);
    wr(BLK_CNT_A, 32'hFFFFFF00);
    rd_is("counter a equal value", BLK_CNT_A, 32'hFFFFFF00);
    wr(BLK_CNT_A, 32'hFFFFFFF0);
    rd_is("counter a higher value", BLK_CNT_A, 32'hFFFFFF00);
    wr(BLK_CNT_A, 32'h00000000);
    wr(BLK_CNT_A, ALL_ONES);
    rd_is("counter a exhausted", BLK_CNT_A, 32'h00000000);
    $display("test counters done");
  endtask

  task automatic t_otp_reload();
    logic [31:0] old;
    rd(8'h00);
    old = v;
    wr(8'h00, 32'h0F0F0F0F);
    rd_is("otp clear only", 8'h00, old & 32'h0F0F0F0F);
    wr(BLK_CNT_RLD, 32'hFFDFFFFF);
    rd_is("reload counter stored", BLK_CNT_RLD, 32'hFFDFFFFF);
    wr(8'h00, 32'h12345678);
    rd_is("otp erased on reload", 8'h00, 32'h12345678);
    wr(BLK_OTP_LAST, 32'hA5A5A5A5);
    rd_is("last otp erased", BLK_OTP_LAST, 32'hA5A5A5A5);
    xfer(CMD_SELECT, ID, 32'h0, 1'h0);
    wr(8'h00, ALL_ONES);
    rd_is("reload ends at select", 8'h00, 32'h12345678);
    $display("test otp_reload done");
  endtask

  task automatic t_eeprom();
    logic [7:0] blk [2] = '{8'h10, BLK_EE_LAST};
    foreach (blk[i])
    begin
      wr(blk[i], 32'hA5A5A5A5);
      wr(blk[i], 32'h5A5A5A5A);
      rd_is("eeprom erased first", blk[i], 32'h5A5A5A5A);
    end
    rd_is("unmapped block", 8'hC8, ALL_ONES);
    $display("test eeprom done");
  endtask

  task automatic t_lock();
    logic [31:0] sys;
    for (int b = 7; b <= 10; b++)
      wr(8'(b), 32'h11110000 | 32'(b));
    rd(BLK_SYS);
    sys = v;
    wr(BLK_SYS, 32'hFCFFFFFF);
    rd_is("system block clear only", BLK_SYS, sys & 32'hFCFFFFFF);
    wr(BLK_SYS, ALL_ONES);
    rd_is("lock bits stay cleared", BLK_SYS, sys & 32'hFCFFFFFF);
    for (int b = 7; b <= 10; b++)
    begin
      wr(8'(b), 32'h22220000);
      rd_is("lock gate", 8'(b), (b < 10) ? (32'h11110000 | 32'(b)) : 32'h22220000);
    end
    $display("test lock done");
  endtask

  task automatic t_bad_frames();
    xfer(CMD_READ, BLK_CNT_RLD, 32'h0, 1'h1);
    chk("bad crc silent", 32'h0, 32'(got));
    xfer(8'h55, BLK_CNT_RLD, 32'h0, 1'h0);
    chk("unknown command silent", 32'h0, 32'(got));
    xfer(CMD_WRITE, 8'h10, 32'h0, 1'h1);
    rd_is("bad crc write dropped", 8'h10, 32'h5A5A5A5A);
    $display("test bad_frames done");
  endtask

  // drops the field while the counter is programming
  task automatic t_tearing();
    int n;
    n = 0;
    send(CMD_WRITE, BLK_CNT_RLD, 32'hFFDFFF00, 1'h0);
    while (prog_busy !== 1'h1)
    begin
      @(negedge clk);
      n++;
      if (n > 200)
        hang("programming start");
    end
    power_ok = 1'h0;
    repeat (8) @(negedge clk);
    chk("power off state", 32'h0, 32'(tag_state));
    xfer(CMD_INITIATE, 8'h00, 32'h0, 1'h0);
    chk("power off silent", 32'h0, 32'(got));
    power_ok = 1'h1;
    wait_ready();
    open_session();
    rd_is("torn counter kept", BLK_CNT_RLD, 32'hFFDFFFFF);
    $display("test tearing done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    t_power_up();
    t_counters();
    t_otp_reload();
    t_eeprom();
    t_lock();
    t_bad_frames();
    t_tearing();
    stop_test();
  end
endmodule
